/* hw/overrange_nco_preset_ctrl.sv */
// Overview of operation
// - Quadrature sample at threshold sets bit 1.
// - In-phase sample at threshold sets bit 0.
// - Threshold scales as level over 256.
// - Pin enable low holds indicator pins low.
// - Carried over-range bits ignore pin enable.
// - Pins stretch 8 times two-to-exponent cycles.
// - Four frequency/phase presets per down-converter.
// - Mode 0 picks presets from register.
// - Mode 1 uses pin pairs A, B.
// - Mode 2 uses pair A; mode 3 reserved.
// - Single-channel follows down-converter A's method.
// - Mode 0 bits 3:2 pick B's preset.
// - Single-channel ignores B's preset field.
// - Mode 0 bits 1:0 pick A's preset.
// - Binding register resets to 0x02.
// - Binding bits route ADC channels to digital.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "orn_regs.svh"
module overrange_nco_preset_ctrl #(
    parameter int SW = 16,
    parameter int FW = 32,
    parameter int PW = 16
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [15:0]   s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [15:0]   s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic          sample_valid,
    input  wire logic [SW-1:0] ddc_a_i,
    input  wire logic [SW-1:0] ddc_a_q,
    input  wire logic [SW-1:0] ddc_b_i,
    input  wire logic [SW-1:0] ddc_b_q,
    input  wire logic [1:0]    preset_pins_a,
    input  wire logic [1:0]    preset_pins_b,
    output logic [1:0]         ovr_bits_a,
    output logic [1:0]         ovr_bits_b,
    output logic               range_pin_a_low,
    output logic               range_pin_a_high,
    output logic               range_pin_b_low,
    output logic               range_pin_b_high,
    output logic [1:0]         active_pick_a,
    output logic [1:0]         active_pick_b,
    output logic [FW-1:0]      osc_freq_a,
    output logic [PW-1:0]      osc_phase_a,
    output logic [FW-1:0]      osc_freq_b,
    output logic [PW-1:0]      osc_phase_b,
    output logic               chan_a_from_b,
    output logic               chan_b_from_b,
    output logic               dig_pd_a,
    output logic               dig_pd_b
);
    import orn_pkg::*;

    // =============================================================
    // Helpers
    function automatic logic over_level(input logic [SW-1:0] s, input logic [7:0] thr);
        logic [SW-1:0] mag;
        logic [SW-1:0] lvl;
        // Negating the most negative code wraps to 2^(SW-1), the true magnitude.
        mag = s[SW-1] ? SW'(-s) : s;
        lvl = SW'({thr, {(SW-9){1'b0}}});
        return mag >= lvl;
    endfunction : over_level

    function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int k = 0; k < 4; k++) begin
            if (strb[k]) begin
                r[k*8 +: 8] = d[k*8 +: 8];
            end
        end
        return r;
    endfunction : merge32

    // =============================================================
    // Register file and bus slave
    logic [7:0]        thr_i_reg, thr_i_next, thr_q_reg, thr_q_next;
    overrange_config_t cfg_reg, cfg_next;
    preset_mode_t      mode_reg, mode_next;
    preset_select_t    sel_reg, sel_next;
    logic [1:0]        bind_reg, bind_next;
    logic [2:0]        ctl_reg, ctl_next;
    logic [FW-1:0]     freq_a_reg [4], freq_a_next [4], freq_b_reg [4], freq_b_next [4];
    logic [PW-1:0]     phase_a_reg [4], phase_a_next [4], phase_b_reg [4], phase_b_next [4];
    logic              awv_reg, awv_next, wv_reg, wv_next;
    logic [11:0]       awidx_reg, awidx_next;
    logic [31:0]       wdata_reg, wdata_next;
    logic [3:0]        wstrb_reg, wstrb_next;
    logic              awready_reg, awready_next, wready_reg, wready_next;
    logic              bvalid_reg, bvalid_next, rvalid_reg, rvalid_next, arready_reg, arready_next;
    logic [1:0]        bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0]       rdata_reg, rdata_next;
    logic [3:0]        pin_reg;
    logic [1:0]        pick_a_reg, pick_b_reg;
    logic              dig_pd_a_reg, dig_pd_b_reg;
    logic [11:0]       ridx;
    logic              hit;

    always_comb begin
        thr_i_next = thr_i_reg;
        thr_q_next = thr_q_reg;
        cfg_next = cfg_reg;
        mode_next = mode_reg;
        sel_next = sel_reg;
        bind_next = bind_reg;
        ctl_next = ctl_reg;
        freq_a_next = freq_a_reg;
        freq_b_next = freq_b_reg;
        phase_a_next = phase_a_reg;
        phase_b_next = phase_b_reg;
        awv_next = awv_reg;
        wv_next = wv_reg;
        awidx_next = awidx_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg && !s_axi_bready;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg && !s_axi_rready;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        hit = 1'b1;
        ridx = s_axi_araddr[13:2];
        if (s_axi_awvalid && awready_reg) begin
            awv_next = 1'b1;
            awidx_next = s_axi_awaddr[13:2];
        end
        if (s_axi_wvalid && wready_reg) begin
            wv_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        // Address and data may arrive in either order; commit once both are held.
        if (awv_reg && wv_reg && !bvalid_reg) begin
            awv_next = 1'b0;
            wv_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = `ORN_RESP_OKAY;
            case (awidx_reg)
                `ORN_IDX_THR_I: if (wstrb_reg[0]) thr_i_next = wdata_reg[7:0];
                `ORN_IDX_THR_Q: if (wstrb_reg[0]) thr_q_next = wdata_reg[7:0];
                `ORN_IDX_CFG:   if (wstrb_reg[0]) cfg_next = wdata_reg[7:0];
                `ORN_IDX_MODE:  if (wstrb_reg[0]) mode_next = preset_mode_t'(wdata_reg[1:0]);
                `ORN_IDX_SEL:   if (wstrb_reg[0]) sel_next = wdata_reg[7:0];
                `ORN_IDX_BIND:  if (wstrb_reg[0]) bind_next = wdata_reg[1:0];
                `ORN_IDX_CTL:   if (wstrb_reg[0]) ctl_next = wdata_reg[2:0];
                `ORN_IDX_STAT:  bresp_next = `ORN_RESP_OKAY;
                default: begin
                    if (awidx_reg[11:4] == 8'(`ORN_IDX_FREQ_A >> 4)) begin
                        case (awidx_reg[3:2])
                            2'h0: freq_a_next[awidx_reg[1:0]] =
                                      FW'(merge32(32'(freq_a_reg[awidx_reg[1:0]]), wdata_reg, wstrb_reg));
                            2'h1: freq_b_next[awidx_reg[1:0]] =
                                      FW'(merge32(32'(freq_b_reg[awidx_reg[1:0]]), wdata_reg, wstrb_reg));
                            2'h2: phase_a_next[awidx_reg[1:0]] =
                                      PW'(merge32(32'(phase_a_reg[awidx_reg[1:0]]), wdata_reg, wstrb_reg));
                            default: phase_b_next[awidx_reg[1:0]] =
                                      PW'(merge32(32'(phase_b_reg[awidx_reg[1:0]]), wdata_reg, wstrb_reg));
                        endcase
                    end else begin
                        bresp_next = `ORN_RESP_SLVERR;
                    end
                end
            endcase
        end
        if (s_axi_arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rdata_next = 32'h0;
            case (ridx)
                `ORN_IDX_THR_I: rdata_next = 32'(thr_i_reg);
                `ORN_IDX_THR_Q: rdata_next = 32'(thr_q_reg);
                `ORN_IDX_CFG:   rdata_next = 32'(cfg_reg);
                `ORN_IDX_MODE:  rdata_next = 32'(mode_reg);
                `ORN_IDX_SEL:   rdata_next = 32'(sel_reg);
                `ORN_IDX_BIND:  rdata_next = 32'(bind_reg);
                `ORN_IDX_CTL:   rdata_next = 32'(ctl_reg);
                `ORN_IDX_STAT:  rdata_next = 32'({dig_pd_b_reg, dig_pd_a_reg, pin_reg, pick_b_reg, pick_a_reg});
                default: begin
                    if (ridx[11:4] == 8'(`ORN_IDX_FREQ_A >> 4)) begin
                        case (ridx[3:2])
                            2'h0: rdata_next = 32'(freq_a_reg[ridx[1:0]]);
                            2'h1: rdata_next = 32'(freq_b_reg[ridx[1:0]]);
                            2'h2: rdata_next = 32'(phase_a_reg[ridx[1:0]]);
                            default: rdata_next = 32'(phase_b_reg[ridx[1:0]]);
                        endcase
                    end else begin
                        hit = 1'b0;
                    end
                end
            endcase
            rresp_next = hit ? `ORN_RESP_OKAY : `ORN_RESP_SLVERR;
        end
        awready_next = !awv_next && !bvalid_next;
        wready_next = !wv_next && !bvalid_next;
        arready_next = !rvalid_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            thr_i_reg <= `ORN_RST_THR_I;
            thr_q_reg <= `ORN_RST_THR_Q;
            cfg_reg <= `ORN_RST_CFG;
            mode_reg <= MODE_REGISTER;
            sel_reg <= `ORN_RST_SEL;
            bind_reg <= `ORN_RST_BIND;
            ctl_reg <= `ORN_RST_CTL;
            for (int k = 0; k < 4; k++) begin
                freq_a_reg[k] <= '0;
                freq_b_reg[k] <= '0;
                phase_a_reg[k] <= '0;
                phase_b_reg[k] <= '0;
            end
            awv_reg <= 1'b0;
            wv_reg <= 1'b0;
            awidx_reg <= 12'h000;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            arready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            rvalid_reg <= 1'b0;
            rresp_reg <= 2'h0;
            rdata_reg <= 32'h0;
        end else begin
            thr_i_reg <= thr_i_next;
            thr_q_reg <= thr_q_next;
            cfg_reg <= cfg_next;
            mode_reg <= mode_next;
            sel_reg <= sel_next;
            bind_reg <= bind_next;
            ctl_reg <= ctl_next;
            freq_a_reg <= freq_a_next;
            freq_b_reg <= freq_b_next;
            phase_a_reg <= phase_a_next;
            phase_b_reg <= phase_b_next;
            awv_reg <= awv_next;
            wv_reg <= wv_next;
            awidx_reg <= awidx_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            arready_reg <= arready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    // =============================================================
    // Over-range detection and pin stretching
    logic [3:0]  det;
    logic [3:0]  ovr_reg, ovr_next, pin_next;
    logic [10:0] cnt_reg [4], cnt_next [4];
    logic [10:0] stretch_len;

    always_comb begin
        det[0] = sample_valid && over_level(ddc_a_i, thr_i_reg);
        det[1] = sample_valid && over_level(ddc_a_q, thr_q_reg);
        det[2] = sample_valid && over_level(ddc_b_i, thr_i_reg);
        det[3] = sample_valid && over_level(ddc_b_q, thr_q_reg);
        // Carried bits never look at the pin enable.
        ovr_next = det;
        stretch_len = `ORN_STRETCH_BASE << cfg_reg.pulse_stretch_exp;
        for (int k = 0; k < 4; k++) begin
            // A fresh hit reloads the full count, so the quiet period restarts.
            cnt_next[k] = det[k] ? 11'(stretch_len - 11'h001)
                        : (cnt_reg[k] != 11'h000) ? 11'(cnt_reg[k] - 11'h001) : 11'h000;
            pin_next[k] = cfg_reg.range_pin_enable && (det[k] || cnt_reg[k] != 11'h000);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovr_reg <= 4'h0;
            pin_reg <= 4'h0;
            for (int k = 0; k < 4; k++) begin
                cnt_reg[k] <= 11'h000;
            end
        end else begin
            ovr_reg <= ovr_next;
            pin_reg <= pin_next;
            cnt_reg <= cnt_next;
        end
    end

    assign ovr_bits_a = ovr_reg[1:0];
    assign ovr_bits_b = ovr_reg[3:2];
    assign range_pin_a_low = pin_reg[0];
    assign range_pin_a_high = pin_reg[1];
    assign range_pin_b_low = pin_reg[2];
    assign range_pin_b_high = pin_reg[3];

    // =============================================================
    // Preset selection, binding and power-down
    logic [1:0]    pa_s1, pa_s2, pb_s1, pb_s2, pick_a_next, pick_b_next;
    logic [FW-1:0] fa_reg, fb_reg;
    logic [PW-1:0] ph_a_reg, ph_b_reg;
    logic          single;
    logic [1:0]    chan_from_b_reg;

    always_comb begin
        single = ctl_reg[`ORN_BIT_SINGLE];
        case (mode_reg)
            MODE_PINS_SPLIT: begin
                pick_a_next = pa_s2;
                pick_b_next = pb_s2;
            end
            MODE_PINS_SHARED: begin
                pick_a_next = pa_s2;
                pick_b_next = pa_s2;
            end
            default: begin
                // Reserved mode 3 falls back to register selection.
                pick_a_next = sel_reg.preset_pick_a;
                pick_b_next = sel_reg.preset_pick_b;
            end
        endcase
        if (single) begin
            pick_b_next = pick_a_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pa_s1 <= 2'h0;
            pa_s2 <= 2'h0;
            pb_s1 <= 2'h0;
            pb_s2 <= 2'h0;
            pick_a_reg <= 2'h0;
            pick_b_reg <= 2'h0;
            fa_reg <= '0;
            fb_reg <= '0;
            ph_a_reg <= '0;
            ph_b_reg <= '0;
            chan_from_b_reg <= `ORN_RST_BIND;
            dig_pd_a_reg <= 1'b0;
            dig_pd_b_reg <= 1'b0;
        end else begin
            pa_s1 <= preset_pins_a;
            pa_s2 <= pa_s1;
            pb_s1 <= preset_pins_b;
            pb_s2 <= pb_s1;
            pick_a_reg <= pick_a_next;
            pick_b_reg <= pick_b_next;
            // Frequency and phase load from the same pick in one edge, never half updated.
            fa_reg <= freq_a_reg[pick_a_next];
            ph_a_reg <= phase_a_reg[pick_a_next];
            fb_reg <= freq_b_reg[pick_b_next];
            ph_b_reg <= phase_b_reg[pick_b_next];
            chan_from_b_reg <= bind_reg;
            dig_pd_a_reg <= bind_reg[0] ? ctl_reg[`ORN_BIT_PD_B] : ctl_reg[`ORN_BIT_PD_A];
            dig_pd_b_reg <= bind_reg[1] ? ctl_reg[`ORN_BIT_PD_B] : ctl_reg[`ORN_BIT_PD_A];
        end
    end

    assign active_pick_a = pick_a_reg;
    assign active_pick_b = pick_b_reg;
    assign osc_freq_a = fa_reg;
    assign osc_phase_a = ph_a_reg;
    assign osc_freq_b = fb_reg;
    assign osc_phase_b = ph_b_reg;
    assign chan_a_from_b = chan_from_b_reg[0];
    assign chan_b_from_b = chan_from_b_reg[1];
    assign dig_pd_a = dig_pd_a_reg;
    assign dig_pd_b = dig_pd_b_reg;

    // =============================================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_q_detect;
        det[1] |=> ovr_bits_a[1];
    endproperty
    a_q_detect: assert property (p_q_detect) else $error("Q over-range bit missed.");
    property p_i_level;
        sample_valid && over_level(ddc_a_i, thr_i_reg) |=> ovr_bits_a[0];
    endproperty
    a_i_level: assert property (p_i_level) else $error("I over-range bit missed.");
    property p_pin_off;
        !cfg_reg.range_pin_enable |=> !range_pin_a_low && !range_pin_b_high;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("Pin high while disabled.");
    property p_carry_free;
        !cfg_reg.range_pin_enable && det[2] |=> ovr_bits_b[0] && !range_pin_b_low;
    endproperty
    a_carry_free: assert property (p_carry_free) else $error("Carried bit gated.");
    property p_min_pulse;
        det[0] && cfg_reg.range_pin_enable && cfg_reg.pulse_stretch_exp == 3'h0 ##1
            (cfg_reg.range_pin_enable && cfg_reg.pulse_stretch_exp == 3'h0) [*8] |-> range_pin_a_low;
    endproperty
    a_min_pulse: assert property (p_min_pulse) else $error("Pulse shorter than minimum.");
    property p_restart;
        det[1] |=> cnt_reg[1] == stretch_len - 11'h001 || $past(stretch_len) != stretch_len;
    endproperty
    a_restart: assert property (p_restart) else $error("Stretch count not reloaded.");
    property p_mode0;
        mode_reg == MODE_REGISTER && !single |=> active_pick_b == $past(sel_reg.preset_pick_b)
            && active_pick_a == $past(sel_reg.preset_pick_a);
    endproperty
    a_mode0: assert property (p_mode0) else $error("Register pick not applied.");
    property p_mode_pins;
        mode_reg == MODE_PINS_SHARED && $stable(mode_reg) && !single |=>
            active_pick_b == $past(preset_pins_a, 3);
    endproperty
    a_mode_pins: assert property (p_mode_pins) else $error("Shared pin pick wrong.");
    property p_single;
        single |=> active_pick_b == active_pick_a;
    endproperty
    a_single: assert property (p_single) else $error("Single mode B pick differs.");
    property p_powerdown;
        bind_reg == 2'h2 && ctl_reg[`ORN_BIT_PD_B] |=> dig_pd_b && dig_pd_a == $past(ctl_reg[`ORN_BIT_PD_A]);
    endproperty
    a_powerdown: assert property (p_powerdown) else $error("Power-down not bound.");
endmodule : overrange_nco_preset_ctrl
`default_nettype wire

/* hw/orn_regs.svh */
`ifndef ORN_REGS_SVH
`define ORN_REGS_SVH
// =============================================================
// Register indices; byte address is four times the index.
`define ORN_IDX_THR_I     12'h211
`define ORN_IDX_THR_Q     12'h212
`define ORN_IDX_CFG       12'h213
`define ORN_IDX_MODE      12'h214
`define ORN_IDX_SEL       12'h215
`define ORN_IDX_BIND      12'h216
`define ORN_IDX_CTL       12'h2f0
`define ORN_IDX_STAT      12'h2f1
`define ORN_IDX_FREQ_A    12'h300
`define ORN_IDX_FREQ_B    12'h304
`define ORN_IDX_PHASE_A   12'h308
`define ORN_IDX_PHASE_B   12'h30c
// =============================================================
// Reset values.
`define ORN_RST_THR_I     8'hf2
`define ORN_RST_THR_Q     8'hab
`define ORN_RST_CFG       8'h07
`define ORN_RST_MODE      2'h0
`define ORN_RST_SEL       8'h00
`define ORN_RST_BIND      2'h2
`define ORN_RST_CTL       3'h0
// =============================================================
// Field positions and timing.
`define ORN_BIT_PIN_EN    3
`define ORN_BIT_SINGLE    0
`define ORN_BIT_PD_A      1
`define ORN_BIT_PD_B      2
`define ORN_STRETCH_BASE  11'h008
`define ORN_RESP_OKAY     2'h0
`define ORN_RESP_SLVERR   2'h2
`endif

/* hw/orn_pkg.sv */
package orn_pkg;
    typedef struct packed {
        logic [3:0] reserved;
        logic       range_pin_enable;
        logic [2:0] pulse_stretch_exp;
    } overrange_config_t;
    typedef struct packed {
        logic [3:0] reserved;
        logic [1:0] preset_pick_b;
        logic [1:0] preset_pick_a;
    } preset_select_t;
    typedef enum logic [1:0] {
        MODE_REGISTER,
        MODE_PINS_SPLIT,
        MODE_PINS_SHARED,
        MODE_RESERVED
    } preset_mode_t;
endpackage : orn_pkg

/* testbench/orn_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module orn_host_model (
    input  wire logic [1:0] want_a,
    input  wire logic [1:0] want_b,
    input  wire logic       aclk,
    input  wire logic       watch_pin,
    output var  logic [1:0] preset_pins_a,
    output var  logic [1:0] preset_pins_b,
    output var  int         high_len
);
    // ============================================================
    // Host pins and pulse watch.
    int run;
    initial {preset_pins_a, preset_pins_b, high_len, run} = '0;
    // Pins move just after an edge, as a host register would.
    always @(posedge aclk) begin
        preset_pins_a <= want_a;
        preset_pins_b <= want_b;
        run <= watch_pin ? run + 1 : 0;
        if (!watch_pin && run != 0) high_len <= run;
    end
endmodule : orn_host_model
`default_nettype wire

/* testbench/overrange_nco_preset_ctrl_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "orn_regs.svh"
module overrange_nco_preset_ctrl_tb_top;
    // ============================================================
    // Bench signals.
    logic aclk = 1'h0, aresetn = 1'h0, sample_valid = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [15:0] ddc_a_i = '0, ddc_a_q = '0, ddc_b_i = '0, ddc_b_q = '0;
    logic [31:0] s_axi_wdata = '0, rdv;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] want_a = '0, want_b = '0, rsp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic range_pin_a_low, range_pin_a_high, range_pin_b_low, range_pin_b_high;
    logic chan_a_from_b, chan_b_from_b, dig_pd_a, dig_pd_b;
    logic [1:0] s_axi_bresp, s_axi_rresp, ovr_bits_a, ovr_bits_b;
    logic [1:0] active_pick_a, active_pick_b, preset_pins_a, preset_pins_b;
    logic [31:0] s_axi_rdata, osc_freq_a, osc_freq_b;
    logic [15:0] osc_phase_a, osc_phase_b;
    int high_len, miscompares = 0, num_checks = 0;
    overrange_nco_preset_ctrl overrange_nco_preset_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .sample_valid, .ddc_a_i, .ddc_a_q, .ddc_b_i, .ddc_b_q, .preset_pins_a, .preset_pins_b,
        .ovr_bits_a, .ovr_bits_b, .range_pin_a_low, .range_pin_a_high, .range_pin_b_low, .range_pin_b_high,
        .active_pick_a, .active_pick_b, .osc_freq_a, .osc_phase_a, .osc_freq_b, .osc_phase_b,
        .chan_a_from_b, .chan_b_from_b, .dig_pd_a, .dig_pd_b);
    orn_host_model orn_host_model_i (.aclk, .want_a, .want_b, .watch_pin(range_pin_a_high),
        .preset_pins_a, .preset_pins_b, .high_len);
    // ============================================================
    // Bus and sample tasks.
    task ck(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask : ck
    task settle(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask : settle
    // Bready is raised with the request, so the response is never missed.
    task wr(input logic [11:0] x, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {2'h0, x, 2'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : wr
    task rd(input logic [11:0] x);
        @(posedge aclk);
        s_axi_araddr <= {2'h0, x, 2'h0};
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        {rdv, rsp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'h0;
    endtask : rd
    task smp(input logic [15:0] i, input logic [15:0] q);
        @(posedge aclk);
        {sample_valid, ddc_a_i, ddc_a_q, ddc_b_i, ddc_b_q} <= {1'h1, i, q, q, i};
        @(posedge aclk);
        sample_valid <= 1'h0;
        #1;
    endtask : smp
    task finish_test;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    // ============================================================
    // Clock, watchdog and tests.
    initial forever #20 aclk = ~aclk;
    initial begin
        repeat (5000) @(posedge aclk);
        miscompares++;
        finish_test;
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`ORN_IDX_THR_I);
        ck(rdv, 32'hf2);
        rd(`ORN_IDX_THR_Q);
        ck(rdv, 32'hab);
        rd(`ORN_IDX_CFG);
        ck(rdv, 32'h07);
        rd(`ORN_IDX_BIND);
        ck(rdv, 32'h02);
        ck(chan_b_from_b, 32'h1);
        rd(12'h100);
        ck(rsp, `ORN_RESP_SLVERR);
        wr(12'h100, 32'h0);
        ck(rsp, `ORN_RESP_SLVERR);
        wr(`ORN_IDX_CFG, 32'h08);
        ck(rsp, `ORN_RESP_OKAY);
        smp(16'h7900, 16'h5580);
        ck(ovr_bits_a, 32'h3);
        ck(ovr_bits_b, 32'h2);
        ck({range_pin_b_high, range_pin_b_low, range_pin_a_high, range_pin_a_low}, 32'hb);
        smp(16'h78ff, 16'h557f);
        ck(ovr_bits_a, 32'h0);
        settle(20);
        ck(high_len, 32'd8);
        smp(16'h0000, 16'haa80);
        ck(ovr_bits_a, 32'h2);
        settle(3);
        smp(16'h0000, 16'haa80);
        settle(30);
        ck(high_len, 32'd13);
        wr(`ORN_IDX_CFG, 32'h01);
        smp(16'h7900, 16'h0000);
        ck(ovr_bits_a, 32'h1);
        settle(2);
        ck(range_pin_a_low, 32'h0);
        settle(20);
        wr(`ORN_IDX_CFG, 32'h09);
        smp(16'h0000, 16'h5580);
        settle(40);
        ck(high_len, 32'd16);
        wr(`ORN_IDX_SEL, 32'h0e);
        wr(`ORN_IDX_FREQ_A + 12'h2, 32'h1234_5678);
        wr(`ORN_IDX_PHASE_B + 12'h3, 32'h0000_abcd);
        settle(4);
        ck({active_pick_b, active_pick_a}, 32'he);
        ck(osc_freq_a, 32'h1234_5678);
        ck(osc_phase_b, 32'habcd);
        {want_a, want_b} <= 4'h6;
        wr(`ORN_IDX_MODE, 32'h1);
        settle(6);
        ck({active_pick_b, active_pick_a}, 32'h9);
        wr(`ORN_IDX_MODE, 32'h2);
        settle(4);
        ck(active_pick_b, 32'h1);
        wr(`ORN_IDX_MODE, 32'h3);
        settle(4);
        ck({active_pick_b, active_pick_a}, 32'he);
        wr(`ORN_IDX_MODE, 32'h0);
        wr(`ORN_IDX_CTL, 32'h1);
        settle(4);
        ck(active_pick_b, 32'h2);
        wr(`ORN_IDX_CTL, 32'h0);
        wr(`ORN_IDX_BIND, 32'h1);
        wr(`ORN_IDX_CTL, 32'h2);
        settle(4);
        ck({chan_b_from_b, chan_a_from_b}, 32'h1);
        ck({dig_pd_b, dig_pd_a}, 32'h2);
        rd(`ORN_IDX_STAT);
        ck(rdv, 32'h20e);
        finish_test;
    end
endmodule : overrange_nco_preset_ctrl_tb_top
`default_nettype wire
